// ==== rtl/ebp_port.sv ====
// external bus port: master drive, slave decode, bank selects, keepers
`timescale 1ns/1ps
module ebp_port #(
  parameter int unsigned IOP_SPACE_BITS = 9
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,
  // configuration
  input  wire logic                         is_master_i,
  input  wire ebp_pkg::ebp_mode_t           mode_i,
  input  wire logic                         sdram_half_i,
  input  wire logic [1:0]                   instr_packing_field_i,
  input  wire logic                         link0_unused_i,
  input  wire logic                         link1_unused_i,
  input  wire logic [2:0]                   processor_id_pins_i,
  input  wire logic                         bus_suspend_n_i,
  input  wire logic                         ack_i,
  // core request side
  input  wire logic                         req_valid_i,
  output logic                              req_ready_o,
  input  wire ebp_pkg::ebp_req_t            req_i,
  output logic                              rsp_valid_o,
  output logic [ebp_pkg::DATA_W-1:0]        rsp_data_o,
  output logic                              full_width_fetch_o,
  output logic                              sdram_tick_o,
  // address pins
  input  wire logic [ebp_pkg::ADDR_W-1:0]   ext_addr_bus_i,
  output logic [ebp_pkg::ADDR_W-1:0]        ext_addr_bus_o,
  output logic                              ext_addr_bus_oe_o,
  // data pins, upper and link-shared lanes
  input  wire logic [ebp_pkg::DATA_W-1:0]   ext_data_i,
  output logic [ebp_pkg::DATA_W-1:0]        ext_data_o,
  output logic                              ext_data_upper_oe_o,
  output logic                              link1_data_pins_oe_o,
  output logic                              link0_data_pins_oe_o,
  // selects and strobes
  input  wire logic [ebp_pkg::BANKS-1:0]    bank_select_n_i,
  output logic [ebp_pkg::BANKS-1:0]         bank_select_n_o,
  output logic                              bank_select_n_oe_o,
  input  wire logic                         rd_n_i,
  input  wire logic                         wr_n_i,
  output logic                              rd_n_o,
  output logic                              wr_n_o,
  output logic                              strobe_oe_o,
  // slave side toward own registers
  output logic                              slv_valid_o,
  output ebp_pkg::ebp_slv_t                 slv_o,
  input  wire logic [ebp_pkg::DATA_W-1:0]   slv_rdata_i,
  output logic                              bus_busy_o,
  output logic                              keeper_en_o
);
  import ebp_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // own register space must leave at least one decoded address bit
  if (IOP_SPACE_BITS == 0 || IOP_SPACE_BITS >= ADDR_W) begin : g_bad_space
    $error("IOP_SPACE_BITS out of range");
  end
  // bank index is two bits wide, so exactly four selects
  if (BANKS != 4) begin : g_bad_banks
    $error("BANKS must be 4");
  end
  // bank fields must sit inside the flat request address
  if (SDR_BITS + 2 > 32 || BANK_BITS + 2 > 32) begin : g_bad_bank_bits
    $error("bank field beyond request address");
  end
  // pin address is cut from the flat request address
  if (ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W wider than request address");
  end
  // link lanes are the bits below the upper lanes
  if (UPPER_LO == 0 || UPPER_LO >= DATA_W) begin : g_bad_upper
    $error("UPPER_LO out of range");
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic drive_ok;
  logic wide_bus;
  // float on suspend or slave
  // suspend floats the pins at once, not one cycle later
  assign drive_ok = is_master_i && bus_suspend_n_i;
  // link lanes join only when unused
  assign wide_bus = link0_unused_i && link1_unused_i;
  assign full_width_fetch_o = wide_bus && (instr_packing_field_i == PACK_FULL);
  // keeper only on id 00x
  // the pad cells hold the level; only the enable leaves this block
  assign keeper_en_o = ((processor_id_pins_i & ID_KEEP_MSK) == ID_KEEP_PAT);

  // ----------------------------------------------------------------
  // sdram rate divider
  // ----------------------------------------------------------------
  logic half_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end
  // sdram half rate: requests and steps only on ticks
  // sdram at full or half rate; sram every cycle
  assign sdram_tick_o = sdram_half_i ? half_q : 1'b1;

  // ----------------------------------------------------------------
  // master state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACC  = 3'b010,
    ST_DONE = 3'b100
  } ebp_state_t;

  ebp_state_t              state_q;
  ebp_req_t                cur_q;
  logic [BANKS-1:0]        sel_n_q;
  logic                    rd_n_q;
  logic                    wr_n_q;
  logic [DATA_W-1:0]       rdata_q;
  logic                    rsp_q;
  logic                    step_ok;
  logic [BANKS-1:0]        bank_dec;
  logic [1:0]              bank_idx;

  // ----------------------------------------------------------------
  // bank decode
  // ----------------------------------------------------------------
  // 16M-word banks, 64M-word for sdram
  assign bank_idx = (mode_i == EBP_SDRAM) ? req_i.addr[SDR_BITS +: 2]
                                          : req_i.addr[BANK_BITS +: 2];
  // remote registers are reached directly by address, no bank
  generate
    for (genvar b = 0; b < BANKS; b++) begin : g_dec
      assign bank_dec[b] = req_i.io_processor_regs || (bank_idx != 2'(b));
    end
  endgenerate

  // halt while suspended; sdram waits for its rate tick
  assign step_ok = drive_ok && (mode_i != EBP_SDRAM || sdram_tick_o);
  assign req_ready_o = (state_q == ST_IDLE) && step_ok;

  logic take;
  logic finish;
  // request accepted on this edge
  assign take   = (state_q == ST_IDLE) && req_valid_i && req_ready_o;
  // a suspended bus holds the access open
  assign finish = (state_q == ST_ACC) && ack_i && step_ok;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      cur_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            cur_q   <= req_i;
            state_q <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (ack_i && step_ok) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          // one idle turn lets async selects return high before the next take
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bank selects, moving with the address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sel_n_q <= '1;
    end else if (state_q == ST_IDLE && req_valid_i && req_ready_o) begin
      sel_n_q <= bank_dec;
    end else if (state_q == ST_ACC && ack_i && step_ok && mode_i != EBP_ASYNC) begin
      sel_n_q <= '1;
    end else if (state_q == ST_DONE) begin
      sel_n_q <= '1;
    end
  end

  // ----------------------------------------------------------------
  // strobes, one assertion per word
  // ----------------------------------------------------------------
  // read strobe per word
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_n_q <= 1'b1;
    end else if (take) begin
      rd_n_q <= req_i.wr;
    end else if (finish) begin
      rd_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_n_q <= 1'b1;
    end else if (take) begin
      wr_n_q <= ~req_i.wr;
    end else if (finish) begin
      wr_n_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  // one-cycle answer pulse, reads only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rsp_q <= 1'b0;
    end else begin
      rsp_q <= finish && !cur_q.wr;
    end
  end

  // link lanes read as zero unless both links are free
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else if (finish) begin
      rdata_q <= ext_data_i;
      if (!wide_bus) begin
        rdata_q[UPPER_LO-1:0] <= '0;
      end
    end
  end
  assign rsp_valid_o = rsp_q;
  assign rsp_data_o  = rdata_q;

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic accessing;
  assign accessing = (state_q == ST_ACC);

  assign ext_addr_bus_o      = cur_q.addr[ADDR_W-1:0];
  assign ext_addr_bus_oe_o   = drive_ok;
  assign bank_select_n_o     = sel_n_q;
  assign bank_select_n_oe_o  = drive_ok;
  assign rd_n_o              = rd_n_q;
  assign wr_n_o              = wr_n_q;
  assign strobe_oe_o         = drive_ok;
  // upper lanes driven on writes only
  // lanes float on reads so the far side can answer
  assign ext_data_o          = cur_q.wdata;
  assign ext_data_upper_oe_o = drive_ok && accessing && cur_q.wr;
  assign link1_data_pins_oe_o = ext_data_upper_oe_o && link1_unused_i;
  assign link0_data_pins_oe_o = ext_data_upper_oe_o && link0_unused_i;

  // ----------------------------------------------------------------
  // slave side
  // ----------------------------------------------------------------
  ebp_slv_t slv_q;
  logic     slv_vld_q;
  logic     busy_q;
  logic     in_space;

  // address taken as input and decoded
  assign in_space = (ext_addr_bus_i[ADDR_W-1:IOP_SPACE_BITS] == '0);

  // remote read marked by low read strobe
  // remote write marked by low write strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      slv_vld_q <= 1'b0;
    end else begin
      slv_vld_q <= !is_master_i && in_space && (!rd_n_i || !wr_n_i);
    end
  end

  // fields follow the pins every cycle; only valid qualifies them
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      slv_q <= '0;
    end else begin
      slv_q.rd    <= !is_master_i && !rd_n_i;
      slv_q.wr    <= !is_master_i && !wr_n_i;
      slv_q.addr  <= ext_addr_bus_i;
      slv_q.wdata <= ext_data_i;
    end
  end
  assign slv_valid_o = slv_vld_q;
  assign slv_o       = slv_q;

  // follow master via its selects
  // own selects are floated as slave, so the pins show the master
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= !is_master_i && (bank_select_n_i != '1);
    end
  end
  assign bus_busy_o = busy_q;

  // slave read data is handed to the register side; not driven here
  logic unused_rdata;
  assign unused_rdata = ^slv_rdata_i;

endmodule : ebp_port

// ==== rtl/ebp_pkg.sv ====
// package for the external bus port: widths, bank decode and carriers
package ebp_pkg;

  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned DATA_W      = 48;
  localparam int unsigned UPPER_LO    = 16;
  localparam int unsigned BANKS       = 4;
  // bank sizes in words, as address bit counts
  localparam int unsigned BANK_BITS   = 24;   // 16M words
  localparam int unsigned SDR_BITS    = 26;   // 64M words
  localparam logic [1:0]  PACK_FULL   = 2'h1; // full width, no packing
  localparam logic [2:0]  ID_KEEP_PAT = 3'h0; // 00x, low bit ignored
  localparam logic [2:0]  ID_KEEP_MSK = 3'h6;

  typedef enum logic [1:0] {
    EBP_ASYNC = 2'h0,
    EBP_SYNC  = 2'h1,
    EBP_SDRAM = 2'h2
  } ebp_mode_t;

  // one request from the core toward the external bus
  typedef struct packed {
    logic                   wr;
    logic                   io_processor_regs;     // target is another processor's registers
    logic [31:0]            addr;    // flat word address, bank in upper bits
    logic [DATA_W-1:0]      wdata;
  } ebp_req_t;

  // a slave access seen on the pins toward our own registers
  typedef struct packed {
    logic                   rd;
    logic                   wr;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      wdata;
  } ebp_slv_t;

endpackage : ebp_pkg

// ==== tb/ebp_port_assertions.sv ====
// checker for the external bus port pins
`timescale 1ns/1ps
module ebp_port_assertions #(parameter int unsigned IOP_SPACE_BITS = 9) (
  // clock, reset, single-bit pins
  input wire logic clk_i, sys_rst_i, is_master_i, bus_suspend_n_i, ack_i, req_valid_i,
  input wire logic req_ready_o, rd_n_o, wr_n_o, rd_n_i, strobe_oe_o, ext_addr_bus_oe_o,
  input wire logic keeper_en_o, rsp_valid_o, slv_valid_o,
  // vectors and carriers
  input wire ebp_pkg::ebp_mode_t mode_i,
  input wire logic [2:0] processor_id_pins_i,
  input wire ebp_pkg::ebp_req_t req_i,
  input wire logic [23:0] ext_addr_bus_i,
  input wire logic [3:0] bank_select_n_o
);
  import ebp_pkg::*;
  logic [1:0] bank_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // bank of the request just taken
  always_ff @(posedge clk_i) begin
    bank_q <= req_i.addr[25:24];
  end
  sequence s_take;
    req_valid_i && req_ready_o;
  endsequence
  sequence s_end;
    (!rd_n_o || !wr_n_o) && ack_i && is_master_i && bus_suspend_n_i;
  endsequence
  a_read_strobe: assert property (s_take and !req_i.wr |=> !rd_n_o && wr_n_o)
    else $error("read strobe missing");
  a_write_strobe: assert property (s_take and req_i.wr |=> !wr_n_o && rd_n_o)
    else $error("write strobe missing");
  a_read_answer: assert property (s_end and !rd_n_o && mode_i != EBP_SDRAM |=> rsp_valid_o)
    else $error("read answer late");
  a_bank_decode: assert property (s_take and !req_i.io_processor_regs && mode_i != EBP_SDRAM
    |=> bank_select_n_o == ~(4'h1 << bank_q)) else $error("wrong bank select");
  a_iop_nosel: assert property (s_take and req_i.io_processor_regs |=> &bank_select_n_o)
    else $error("select on remote register access");
  a_sync_release: assert property (s_end and mode_i == EBP_SYNC |=> &bank_select_n_o)
    else $error("sync select held past ack");
  a_async_hold: assert property (s_end and mode_i == EBP_ASYNC && !(&bank_select_n_o)
    |=> !(&bank_select_n_o) ##1 &bank_select_n_o) else $error("async select timing");
  a_one_bank: assert property ($countones(~bank_select_n_o) <= 1)
    else $error("more than one bank selected");
  a_drive_float: assert property (!is_master_i || !bus_suspend_n_i
    |-> !strobe_oe_o && !ext_addr_bus_oe_o) else $error("pins driven while off bus");
  a_keeper_id: assert property (keeper_en_o == (processor_id_pins_i[2:1] == 2'h0))
    else $error("keeper enable wrong");
  a_slave_take: assert property ($fell(rd_n_i) && !is_master_i
    && ext_addr_bus_i < (1 << IOP_SPACE_BITS) |=> slv_valid_o) else $error("slave read lost");
endmodule : ebp_port_assertions
bind ebp_port ebp_port_assertions #(.IOP_SPACE_BITS(IOP_SPACE_BITS)) u_chk (.*);

// ==== tb/ebp_mem_model.sv ====
// external memory answering the strobes with wait states
`timescale 1ns/1ps
module ebp_mem_model #(parameter int WAITS = 2) (
  input wire logic clk_i, rd_n_i, wr_n_i,
  input wire logic [23:0] addr_i,
  input wire logic [47:0] wdata_i,
  output logic ack_o,
  output logic [47:0] rdata_o, last_wdata_o
);
  logic [3:0] cnt_q = 4'h0;
  logic [47:0] last_q = 48'h0;
  // ack held low for wait states while a strobe is low
  assign ack_o = (cnt_q >= WAITS);
  always_ff @(posedge clk_i) begin
    cnt_q <= (rd_n_i && wr_n_i) ? 4'h0 : cnt_q + 4'h1;
    if (!wr_n_i && ack_o) last_wdata_o <= wdata_i;
    if (!rd_n_i) last_q <= rdata_o;
  end
  // released data shows the inverse so stale values never match
  assign rdata_o = !rd_n_i ? {addr_i, ~addr_i} : ~last_q;
endmodule : ebp_mem_model

// ==== tb/ebp_port_tb_top.sv ====
// testbench for the external bus port
`timescale 1ns/1ps
module ebp_port_tb_top;
  import ebp_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, mst = 1, half = 0, lk0 = 1, lk1 = 1, susp_n = 1;
  logic rv = 0, tb_rd_n = 1, tb_wr_n = 1, rdy, rsv, ff, tk, a_oe, d_oe, s_oe, st_oe;
  logic rd_o, wr_o, rd_i, wr_i, ack, sv, busy, keep, l1oe, l0oe;
  ebp_mode_t mode = EBP_ASYNC;
  logic [1:0] pack = 2'h1;
  logic [2:0] id = 3'h0;
  ebp_req_t req = '0;
  ebp_slv_t slv;
  logic [23:0] tb_addr = 24'h0, a_o, a_i;
  logic [3:0] tb_sel = 4'hf, sel_o, sel_i;
  logic [47:0] rsd, d_o, d_i, mrd, mwr;
  int fails = 0, num_checks = 0, cyc = 0;
  // strobes come from whichever party drives them
  assign rd_i = st_oe ? rd_o : tb_rd_n;
  assign wr_i = st_oe ? wr_o : tb_wr_n;
  assign a_i = a_oe ? a_o : tb_addr;
  assign sel_i = s_oe ? sel_o : tb_sel;
  assign d_i = d_oe ? d_o : mrd;
  ebp_port dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .is_master_i(mst), .mode_i(mode),
    .sdram_half_i(half), .instr_packing_field_i(pack), .link0_unused_i(lk0),
    .link1_unused_i(lk1), .processor_id_pins_i(id), .bus_suspend_n_i(susp_n), .ack_i(ack),
    .req_valid_i(rv), .req_ready_o(rdy), .req_i(req), .rsp_valid_o(rsv), .rsp_data_o(rsd),
    .full_width_fetch_o(ff), .sdram_tick_o(tk), .ext_addr_bus_i(a_i), .ext_addr_bus_o(a_o),
    .ext_addr_bus_oe_o(a_oe), .ext_data_i(d_i), .ext_data_o(d_o), .ext_data_upper_oe_o(d_oe),
    .link1_data_pins_oe_o(l1oe), .link0_data_pins_oe_o(l0oe), .bank_select_n_i(sel_i),
    .bank_select_n_o(sel_o), .bank_select_n_oe_o(s_oe), .rd_n_i(rd_i), .wr_n_i(wr_i),
    .rd_n_o(rd_o), .wr_n_o(wr_o), .strobe_oe_o(st_oe), .slv_valid_o(sv), .slv_o(slv),
    .slv_rdata_i(48'h0), .bus_busy_o(busy), .keeper_en_o(keep));
  ebp_mem_model mem (.clk_i(clk_i), .rd_n_i(rd_i), .wr_n_i(wr_i), .addr_i(a_i),
    .wdata_i(d_i), .ack_o(ack), .rdata_o(mrd), .last_wdata_o(mwr));
  always #25 clk_i = ~clk_i;
  // ceiling well above the fifty or so cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask : step
  task automatic wait_for(ref logic s);
    int n = 0;
    while (s !== 1'b1 && n < 60) begin
      step();
      n++;
    end
  endtask : wait_for
  task automatic access(input logic wr, input logic io_processor_regs, input logic [31:0] ad);
    wait_for(rdy);
    req = '{wr: wr, io_processor_regs: io_processor_regs, addr: ad, wdata: {ad[23:0], 24'h5a5a5a}};
    rv = 1;
    step();
    rv = 0;
  endtask : access
  task automatic t_read(input ebp_mode_t m, input logic [31:0] ad, input logic lk);
    logic [47:0] e;
    logic [3:0] es;
    mode = m;
    half = (m == EBP_SDRAM);
    lk0 = lk;
    lk1 = lk;
    e = {ad[23:0], ~ad[23:0]};
    if (!lk) e[15:0] = 16'h0;
    es = ~(4'h1 << (m == EBP_SDRAM ? ad[27:26] : ad[25:24]));
    access(1'b0, 1'b0, ad);
    chk(sel_o, es);
    chk(a_o, ad[23:0]);
    chk(rd_o, 1'b0);
    wait_for(rsv);
    chk(rsd, e);
    $display("read test done");
  endtask : t_read
  task automatic t_write;
    mode = EBP_SYNC;
    access(1'b1, 1'b0, 32'h0300_0777);
    chk(wr_o, 1'b0);
    chk({d_oe, l1oe, l0oe}, 3'h7);
    wait_for(rdy);
    chk(mwr, 48'h0007_775a_5a5a);
    chk(sel_o, 4'hf);
    $display("write test done");
  endtask : t_write
  task automatic t_iop;
    mode = EBP_ASYNC;
    access(1'b0, 1'b1, 32'h0000_0042);
    chk(sel_o, 4'hf);
    chk(rd_o, 1'b0);
    wait_for(rsv);
    chk(rsv, 1'b1);
    chk(rsd, {24'h000042, ~24'h000042});
    $display("remote register test done");
  endtask : t_iop
  task automatic t_suspend;
    susp_n = 0;
    #1;
    chk({st_oe, a_oe, rdy}, 3'h0);
    step();
    susp_n = 1;
    #1;
    chk(a_oe, 1'b1);
    $display("suspend test done");
  endtask : t_suspend
  task automatic t_slave;
    mst = 0;
    tb_sel = 4'hd;
    tb_addr = 24'h000012;
    // remote reader lowers our read strobe
    tb_rd_n = 0;
    step();
    chk({sv, slv.rd, slv.addr}, {2'h3, 24'h000012});
    chk(st_oe, 1'b0);
    tb_rd_n = 1;
    step();
    chk(busy, 1'b1);
    tb_addr = 24'h000034;
    // remote writer lowers our write strobe
    tb_wr_n = 0;
    step();
    chk({sv, slv.wr, slv.addr}, {2'h3, 24'h000034});
    tb_wr_n = 1;
    tb_sel = 4'hf;
    mst = 1;
    step();
    $display("slave test done");
  endtask : t_slave
  task automatic t_config;
    for (int i = 0; i < 8; i++) begin
      id = i[2:0];
      step();
      chk(keep, i < 2);
    end
    for (int i = 0; i < 5; i++) begin
      pack = (i == 4) ? 2'h1 : i[1:0];
      lk0 = (i != 4);
      step();
      chk(ff, i == 1);
    end
    $display("config test done");
  endtask : t_config
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (8) @(posedge clk_i);
    #1 sys_rst_i = 0;
    chk({sel_o, rd_o, wr_o, rsv, sv}, 8'hfc);
    t_read(EBP_ASYNC, 32'h0200_0abc, 1'b1);
    t_read(EBP_SYNC, 32'h0100_0123, 1'b0);
    t_read(EBP_SDRAM, 32'h0c00_0456, 1'b1);
    t_write();
    t_iop();
    t_suspend();
    t_slave();
    t_config();
    tally_and_finish();
  end
endmodule : ebp_port_tb_top
